// ---- i2c_slot_defines.svh ----
`ifndef I2C_SLOT_DEFINES_SVH
`define I2C_SLOT_DEFINES_SVH

// Register offsets
`define REG_PARAM       8'h00
`define REG_FRAME       8'h01
`define REG_SLOT        8'h03
`define REG_LAST        8'h06

// Reset and fill values
`define PARAM_RESET     8'h00
`define READ_FILL       8'hff
`define SLOT_NONE       8'h00
`define SLOT_CRC        8'hff

// Frame buffer layout
`define FB_DEPTH        36
`define IDX_LEN         6'h00
`define IDX_STAT_LO     6'h01
`define IDX_STAT_HI     6'h02
`define RESULT_BASE     6'h03
`define RESULT_LEN      8'h12

// Slot sequence
`define SLOT_LAST       4'hf

// Serial bit counting
`define BYTE_BITS       4'h8
`define ACK_SLOT        4'h9

// Device type code, value arbitrary
`define DEV_TYPE_DEFAULT 4'h5

`endif

// ---- i2c_slot_pkg.sv ----
package i2c_slot_pkg;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_DEV  = 3'b001,
        BUS_ADDR = 3'b011,
        BUS_WDAT = 3'b010,
        BUS_RDAT = 3'b110,
        BUS_IGN  = 3'b111
    } bus_state_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_CMD  = 3'b001,
        SEQ_WAIT = 3'b011,
        SEQ_STLO = 3'b010,
        SEQ_STHI = 3'b110
    } seq_state_t;

    typedef enum logic [1:0] {
        ANS_OK   = 2'b01,
        ANS_NONE = 2'b00,
        ANS_CRC  = 2'b10
    } ans_kind_t;

endpackage

// ---- pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_q;

    // Pins idle high on an open-drain bus
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q  <= '1;
            pin_out <= '1;
        end else begin
            meta_q  <= pin_in;
            pin_out <= meta_q;
        end
    end
endmodule // pin_sync

`default_nettype wire

// ---- slot_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slot_defines.svh"

module slot_sequencer
    import i2c_slot_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Launch
    input  wire logic       start,
    output logic            busy,
    // Transceiver side
    output logic            cmd_stb,
    output logic [3:0]      cmd_num,
    input  wire logic       ans_stb,
    input  wire logic [1:0] ans_kind,
    input  wire logic [7:0] ans_id,
    // Result writes
    output logic            we,
    output logic [5:0]      widx,
    output logic [7:0]      wdata
);
    seq_state_t  state_q;
    logic [3:0]  slot_q;
    logic [15:0] status_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SEQ_IDLE;
            slot_q  <= 4'h0;
        end else begin
            unique case (state_q)
                SEQ_IDLE: if (start) begin
                    state_q <= SEQ_CMD;
                    slot_q  <= 4'h0;
                end
                SEQ_CMD:  state_q <= SEQ_WAIT;
                SEQ_WAIT: if (ans_stb) begin
                    if (slot_q == `SLOT_LAST) begin
                        state_q <= SEQ_STLO;
                    end else begin
                        slot_q  <= slot_q + 4'h1;
                        state_q <= SEQ_CMD;
                    end
                end
                SEQ_STLO: state_q <= SEQ_STHI;
                SEQ_STHI: state_q <= SEQ_IDLE;
                default:  state_q <= SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 16'h0000;
        end else if (state_q == SEQ_IDLE && start) begin
            status_q <= 16'h0000;
        end else if (state_q == SEQ_WAIT && ans_stb) begin
            status_q[slot_q] <= (ans_kind == ANS_OK);
        end
    end

    // Slot 0 carries the poll-all command, later numbers are slot advances
    assign cmd_stb = (state_q == SEQ_CMD);
    assign cmd_num = slot_q;
    assign busy    = (state_q != SEQ_IDLE);

    always_comb begin
        we    = 1'b0;
        widx  = `IDX_LEN;
        wdata = `RESULT_LEN;
        unique case (state_q)
            SEQ_IDLE: we = start;
            SEQ_WAIT: begin
                we   = ans_stb;
                widx = `RESULT_BASE + {2'b00, slot_q};
                if (ans_kind == ANS_OK) begin
                    wdata = ans_id;
                end else if (ans_kind == ANS_CRC) begin
                    wdata = `SLOT_CRC;
                end else begin
                    wdata = `SLOT_NONE;
                end
            end
            SEQ_STLO: begin
                we    = 1'b1;
                widx  = `IDX_STAT_LO;
                wdata = status_q[7:0];
            end
            SEQ_STHI: begin
                we    = 1'b1;
                widx  = `IDX_STAT_HI;
                wdata = status_q[15:8];
            end
            default: we = 1'b0;
        endcase
    end

    sequence s_slot_answered;
        state_q == SEQ_WAIT && ans_stb && slot_q != `SLOT_LAST;
    endsequence

    a_slot_advance: assert property (@(posedge clk) disable iff (!rst_n)
        s_slot_answered |=> cmd_stb && cmd_num == $past(slot_q) + 4'h1)
        else $error("Slot command did not advance by one");

    a_len_byte: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == SEQ_IDLE && start |-> we && widx == `IDX_LEN && wdata == `RESULT_LEN)
        else $error("Byte count not set to 18 on trigger");

    a_slot_result: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == SEQ_WAIT && ans_stb |-> we && widx == `RESULT_BASE + {2'b00, slot_q}
            && wdata == ((ans_kind == ANS_OK) ? ans_id
                       : (ans_kind == ANS_CRC) ? `SLOT_CRC : `SLOT_NONE))
        else $error("Slot identifier byte wrong");

    a_status_bytes: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == SEQ_STLO |=> we && widx == `IDX_STAT_HI && wdata == status_q[15:8]
            && $past(wdata) == status_q[7:0])
        else $error("Status bytes written wrong");
endmodule // slot_sequencer

`default_nettype wire

// ---- i2c_slot_top.sv ----
// Overview of operation
// - Trigger runs poll-all then slots 1-15
// - Valid answer: status one, identifier stored
// - No answer: status zero, byte 00h
// - CRC error: status zero, byte FFh
// - Every trigger sets byte 0 to 18
// - Status flags packed in bytes 1 and 2
// - Slot k identifier lands in byte k+3
// - Results read only through frame buffer
// - Reading trigger register returns FFh repeatedly
// - Select code: type code plus enable pins
// - Eighth select bit gives read or write
// - Matching select byte acknowledged on ninth bit
// - Mismatch: no acknowledge, back to standby
// - Nothing happens before a START
// - No bus response during radio exchange
// - STOP closes the current transfer
// - Read STOP after no-acknowledge gives standby
// - Write STOP after frame or trigger data launches the radio exchange
// - Each written byte acknowledged on ninth bit
// - Transmitter releases SDA, receiver pulls ninth
// - SDA sampled on rising SCL edge
// - Bytes shifted most significant bit first
// - Write: address byte then data bytes
// - Address above 06h: no acknowledge, deselect
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slot_defines.svh"

module i2c_slot_top
    import i2c_slot_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = `DEV_TYPE_DEFAULT, // Arbitrary value
    parameter int         FB_DEPTH = `FB_DEPTH
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // Serial bus
    input  wire logic       SCL_IN,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE_N,
    // Chip enable straps
    input  wire logic       SELECT_PIN_HI,
    input  wire logic       SELECT_PIN_MID,
    input  wire logic       SELECT_PIN_LO,
    // Slot commands to the transceiver
    output logic            SLOT_CMD_STB,
    output logic [3:0]      SLOT_CMD_NUM,
    input  wire logic       SLOT_ANS_STB,
    input  wire logic [1:0] SLOT_ANS_KIND,
    input  wire logic [7:0] SLOT_ANS_ID,
    // Frame exchange and configuration
    output logic            FRAME_TX_START,
    input  wire logic       FRAME_BUSY,
    output logic [7:0]      PARAM_OUT
);
    logic [4:0]  pins_s;
    logic        scl_s;
    logic        sda_s;
    logic [2:0]  sel_s;
    logic        scl_p_q;
    logic        sda_p_q;
    logic        start_c;
    logic        stop_c;
    logic        rise_c;
    logic        fall_c;
    logic        busy;
    logic        seq_busy;
    logic        seq_start;
    logic        seq_we;
    logic [5:0]  seq_widx;
    logic [7:0]  seq_wdata;
    bus_state_t  bus_q;
    logic [3:0]  bit_cnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  tx_q;
    logic        pull_q;
    logic        rw_q;
    logic        mack_q;
    logic [7:0]  ptr_q;
    logic [5:0]  idx_q;
    logic        wr_seen_q;
    logic [7:0]  param_q;
    logic [7:0]  param_pend_q;
    logic        frame_tx_q;
    logic        byte_end_c;
    logic        ack_end_c;
    logic        dev_match;
    logic        addr_ok;
    logic        ack_c;
    logic        load_c;
    logic [7:0]  rd_byte;
    logic        host_we;
    logic [7:0]  fbuf_q [FB_DEPTH];

    localparam logic [5:0] IDX_WRAP = 6'(FB_DEPTH - 1);

    pin_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk     (CLK),
        .rst_n   (RST_N),
        .pin_in  ({SELECT_PIN_HI, SELECT_PIN_MID, SELECT_PIN_LO, SDA_IN, SCL_IN}),
        .pin_out (pins_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign sel_s = pins_s[4:2];

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Bus conditions; START watching stops during radio exchanges
    assign busy    = seq_busy | FRAME_BUSY;
    assign start_c = ~busy & scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_c  = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign rise_c  = scl_s & ~scl_p_q;
    assign fall_c  = ~scl_s & scl_p_q;

    assign byte_end_c = fall_c && bit_cnt_q == `BYTE_BITS;
    assign ack_end_c  = fall_c && bit_cnt_q == `ACK_SLOT;
    assign dev_match  = shift_q[7:1] == {DEV_TYPE, sel_s};
    assign addr_ok    = shift_q <= `REG_LAST;
    assign load_c     = (bus_q == BUS_DEV && rw_q) || (bus_q == BUS_RDAT && mack_q);

    always_comb begin
        unique case (bus_q)
            BUS_DEV:  ack_c = dev_match;
            BUS_ADDR: ack_c = addr_ok;
            BUS_WDAT: ack_c = 1'b1;
            default:  ack_c = 1'b0;
        endcase
    end

    // Trigger register is not readable, it only returns fill bytes
    always_comb begin
        if (ptr_q == `REG_PARAM) begin
            rd_byte = param_q;
        end else if (ptr_q == `REG_FRAME) begin
            rd_byte = fbuf_q[idx_q];
        end else begin
            rd_byte = `READ_FILL;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bus_q <= BUS_IDLE;
        end else if (busy) begin
            bus_q <= BUS_IDLE;
        end else if (start_c) begin
            bus_q <= BUS_DEV;
        end else if (stop_c) begin
            bus_q <= BUS_IDLE;
        end else if (byte_end_c) begin
            if (bus_q == BUS_DEV && !dev_match) begin
                bus_q <= BUS_IDLE;
            end else if (bus_q == BUS_ADDR && !addr_ok) begin
                bus_q <= BUS_IGN;
            end
        end else if (ack_end_c) begin
            unique case (bus_q)
                BUS_DEV:  bus_q <= rw_q ? BUS_RDAT : BUS_ADDR;
                BUS_ADDR: bus_q <= BUS_WDAT;
                BUS_RDAT: if (!mack_q) bus_q <= BUS_IGN;
                default:  bus_q <= bus_q;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bit_cnt_q <= 4'h0;
        end else if (busy || start_c || stop_c || ack_end_c) begin
            bit_cnt_q <= 4'h0;
        end else if (rise_c && bus_q != BUS_IDLE && bus_q != BUS_IGN) begin
            if (bit_cnt_q < `BYTE_BITS) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end else begin
                bit_cnt_q <= `ACK_SLOT;
            end
        end
    end

    // Receive shifter, sampled on rising SCL
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            shift_q <= 8'h00;
        end else if (rise_c && bit_cnt_q < `BYTE_BITS) begin
            shift_q <= {shift_q[6:0], sda_s};
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rw_q   <= 1'b0;
            mack_q <= 1'b0;
        end else begin
            if (byte_end_c && bus_q == BUS_DEV) begin
                rw_q <= shift_q[0];
            end
            if (rise_c && bit_cnt_q == `BYTE_BITS && bus_q == BUS_RDAT) begin
                mack_q <= ~sda_s;
            end
        end
    end

    // Transmit shifter
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_q <= 8'h00;
        end else if (ack_end_c && load_c) begin
            tx_q <= rd_byte;
        end else if (rise_c && bus_q == BUS_RDAT && bit_cnt_q < `BYTE_BITS) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // SDA pull-down, set on falling SCL, released on START, STOP or busy
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pull_q <= 1'b0;
        end else if (busy || start_c || stop_c) begin
            pull_q <= 1'b0;
        end else if (byte_end_c) begin
            pull_q <= ack_c && bus_q != BUS_RDAT;
        end else if (ack_end_c) begin
            pull_q <= load_c && !rd_byte[7];
        end else if (fall_c && bus_q == BUS_RDAT && bit_cnt_q != 4'h0) begin
            pull_q <= ~tx_q[7];
        end
    end

    assign SDA_OUT  = 1'b0;
    assign SDA_OE_N = ~pull_q;

    // Register pointer and buffer index
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ptr_q <= `REG_PARAM;
            idx_q <= 6'h00;
        end else if (byte_end_c && bus_q == BUS_ADDR && addr_ok) begin
            ptr_q <= shift_q;
            idx_q <= 6'h00;
        end else if (byte_end_c && bus_q == BUS_DEV && dev_match && shift_q[0]) begin
            idx_q <= 6'h00;
        end else if (ptr_q == `REG_FRAME && ((byte_end_c && bus_q == BUS_WDAT)
                     || (rise_c && bit_cnt_q == `BYTE_BITS && bus_q == BUS_RDAT && !sda_s))) begin
            idx_q <= (idx_q == IDX_WRAP) ? 6'h00 : idx_q + 6'h01;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_seen_q    <= 1'b0;
            param_pend_q <= `PARAM_RESET;
        end else if (start_c) begin
            wr_seen_q <= 1'b0;
        end else if (byte_end_c && bus_q == BUS_WDAT) begin
            wr_seen_q <= 1'b1;
            if (ptr_q == `REG_PARAM) begin
                param_pend_q <= shift_q;
            end
        end
    end

    // A write STOP with data to the trigger register launches the slot sequence
    assign seq_start = stop_c && bus_q == BUS_WDAT && wr_seen_q && ptr_q == `REG_SLOT;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            param_q    <= `PARAM_RESET;
            frame_tx_q <= 1'b0;
        end else begin
            frame_tx_q <= stop_c && bus_q == BUS_WDAT && wr_seen_q && ptr_q == `REG_FRAME;
            if (stop_c && bus_q == BUS_WDAT && wr_seen_q && ptr_q == `REG_PARAM) begin
                param_q <= param_pend_q;
            end
        end
    end

    assign FRAME_TX_START = frame_tx_q;
    assign PARAM_OUT      = param_q;

    assign host_we = byte_end_c && bus_q == BUS_WDAT && ptr_q == `REG_FRAME;

    // Bus is ignored while the sequencer runs, so writers never collide
    for (genvar i = 0; i < FB_DEPTH; i++) begin : g_fbuf
        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                fbuf_q[i] <= 8'h00;
            end else if (seq_we && seq_widx == 6'(i)) begin
                fbuf_q[i] <= seq_wdata;
            end else if (host_we && idx_q == 6'(i)) begin
                fbuf_q[i] <= shift_q;
            end
        end
    end

    slot_sequencer u_seq (
        .clk      (CLK),
        .rst_n    (RST_N),
        .start    (seq_start),
        .busy     (seq_busy),
        .cmd_stb  (SLOT_CMD_STB),
        .cmd_num  (SLOT_CMD_NUM),
        .ans_stb  (SLOT_ANS_STB),
        .ans_kind (SLOT_ANS_KIND),
        .ans_id   (SLOT_ANS_ID),
        .we       (seq_we),
        .widx     (seq_widx),
        .wdata    (seq_wdata)
    );

    a_select_ack: assert property (@(posedge CLK) disable iff (!RST_N)
        byte_end_c && !busy && !stop_c && bus_q == BUS_DEV && dev_match
        |=> !SDA_OE_N [*2])
        else $error("Matching select byte not acknowledged");

    a_select_miss: assert property (@(posedge CLK) disable iff (!RST_N)
        byte_end_c && !busy && !stop_c && bus_q == BUS_DEV && !dev_match
        |=> SDA_OE_N && bus_q == BUS_IDLE)
        else $error("Mismatched select byte not ignored");

    a_addr_range: assert property (@(posedge CLK) disable iff (!RST_N)
        byte_end_c && !busy && !stop_c && bus_q == BUS_ADDR && !addr_ok
        |=> SDA_OE_N && bus_q == BUS_IGN)
        else $error("Out-of-range address acknowledged");

    a_write_ack: assert property (@(posedge CLK) disable iff (!RST_N)
        byte_end_c && !busy && !stop_c && !start_c && bus_q == BUS_WDAT |=> !SDA_OE_N)
        else $error("Written byte not acknowledged");

    a_busy_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
        busy |=> bus_q == BUS_IDLE && SDA_OE_N)
        else $error("Bus answered during radio exchange");

    a_stop_close: assert property (@(posedge CLK) disable iff (!RST_N)
        stop_c |=> bus_q == BUS_IDLE && SDA_OE_N)
        else $error("STOP did not close the transfer");

    a_trig_launch: assert property (@(posedge CLK) disable iff (!RST_N)
        seq_start |=> seq_busy ##1 fbuf_q[0] == `RESULT_LEN)
        else $error("Write STOP did not launch slot sequence");

    a_slot_fill: assert property (@(posedge CLK) disable iff (!RST_N)
        ack_end_c && bus_q == BUS_RDAT && mack_q && ptr_q == `REG_SLOT
        |=> tx_q == `READ_FILL)
        else $error("Trigger register read not FFh");
endmodule // i2c_slot_top

`default_nettype wire

// ---- i2c_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
    // Bus lines, open drain data
    output logic      scl,
    output logic      sda_drv_n,
    input  wire logic sda
);
    localparam realtime TQ = 31.25;

    // Idle: clock stands high, data released
    initial begin
        scl       = 1'b1;
        sda_drv_n = 1'b1;
    end

    task automatic start();
        sda_drv_n = 1'b1;
        #TQ;
        scl = 1'b1;
        #(2*TQ);
        sda_drv_n = 1'b0;
        #(2*TQ);
        scl = 1'b0;
        #TQ;
    endtask

    task automatic stop();
        sda_drv_n = 1'b0;
        #TQ;
        scl = 1'b1;
        #(2*TQ);
        sda_drv_n = 1'b1;
        #(2*TQ);
    endtask

    // Data set mid-low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        sda_drv_n = b;
        #TQ;
        scl = 1'b1;
        #TQ;
        s = sda;
        #TQ;
        scl = 1'b0;
        #TQ;
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule // i2c_master_model

`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slot_defines.svh"

module tb_top
    import i2c_slot_pkg::*;
;
    localparam logic [3:0] DEV = 4'h6; // Arbitrary type code
    logic CLK, RST_N, SDA_OUT, SDA_OE_N, HI, MID, LO, CMD_STB, TX, FRAME_BUSY;
    logic ANS_STB = 1'b0;
    logic [3:0] CMD_NUM;
    logic [1:0] ANS_KIND = 2'b00;
    logic [7:0] ANS_ID = 8'h00, PARAM_OUT;
    logic scl, drv_n, ok;
    wire logic sda = drv_n & SDA_OE_N;
    logic [31:0] rs = 32'h3d1a;
    logic [2:0] strap;
    logic [1:0] kinds[16];
    logic [7:0] ids[16], wbuf[4], rbuf[19];
    int n_fail = 0, n_tests = 0, n_tx = 0, cmd_exp = 0, cnt = 0, t;

    i2c_slot_top #(.DEV_TYPE(DEV)) dut_u (
        .CLK(CLK), .RST_N(RST_N), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT),
        .SDA_OE_N(SDA_OE_N), .SELECT_PIN_HI(HI), .SELECT_PIN_MID(MID),
        .SELECT_PIN_LO(LO), .SLOT_CMD_STB(CMD_STB), .SLOT_CMD_NUM(CMD_NUM),
        .SLOT_ANS_STB(ANS_STB), .SLOT_ANS_KIND(ANS_KIND), .SLOT_ANS_ID(ANS_ID),
        .FRAME_TX_START(TX), .FRAME_BUSY(FRAME_BUSY), .PARAM_OUT(PARAM_OUT));
    i2c_master_model m_u (.scl(scl), .sda_drv_n(drv_n), .sda(sda));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    function automatic logic [7:0] exp_byte(input int i);
        logic [15:0] flags;
        for (int k = 0; k < 16; k++) flags[k] = (kinds[k] == ANS_OK);
        if (i == 0) return `RESULT_LEN;
        if (i < 3) return (i == 1) ? flags[7:0] : flags[15:8];
        if (kinds[i-3] == ANS_OK) return ids[i-3];
        return (kinds[i-3] == ANS_CRC) ? `SLOT_CRC : `SLOT_NONE;
    endfunction

    function automatic logic [7:0] sel(input logic rw);
        return {DEV, strap, rw};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (n_fail == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic xfer_w(input logic [7:0] s, input logic [7:0] a, input int n);
        logic k;
        m_u.start();
        m_u.put_byte(s, ok);
        if (ok === 1'b1) m_u.put_byte(a, ok);
        for (int i = 0; i < n && ok === 1'b1; i++) begin
            m_u.put_byte(wbuf[i], k);
            ok = k;
        end
        m_u.stop();
    endtask

    task automatic rd(input int n);
        m_u.start();
        m_u.put_byte(sel(1'b1), ok);
        chk(8'(ok), 8'h01);
        for (int i = 0; i < n; i++) m_u.get_byte(i == n - 1, rbuf[i]);
        m_u.stop();
    endtask

    // Transceiver stand-in: answers each command after a delay
    // Sixteen commands per run, so the slot is the running count modulo 16
    always @(negedge CLK) begin
        if (TX) n_tx++;
        ANS_STB <= !CMD_STB && cnt == 1;
        if (CMD_STB) begin
            chk(8'(CMD_NUM), 8'(cmd_exp % 16));
            cnt = 20 + int'(rnd() % 16);
        end else if (cnt > 0) begin
            cnt--;
            if (cnt == 0) begin
                ANS_KIND <= kinds[cmd_exp % 16];
                ANS_ID   <= ids[cmd_exp % 16];
                cmd_exp++;
            end
        end
    end

    initial begin
        RST_N = 1'b0;
        FRAME_BUSY = 1'b0;
        strap = 3'(rnd());
        {HI, MID, LO} = strap;
        repeat (6) @(posedge CLK);
        @(negedge CLK) RST_N = 1'b1;
        repeat (4) @(posedge CLK);
        wbuf[0] = 8'(rnd());
        xfer_w(sel(1'b0), `REG_PARAM, 1);
        chk(8'(ok), 8'h01);
        chk(PARAM_OUT, wbuf[0]);
        for (int i = 0; i < 4; i++) wbuf[i] = 8'(rnd());
        xfer_w(sel(1'b0), `REG_FRAME, 4);
        chk(8'(n_tx), 8'h01);
        @(negedge CLK) FRAME_BUSY = 1'b1;
        xfer_w(sel(1'b0), `REG_FRAME, 0);
        chk(8'(ok), 8'h00);
        @(negedge CLK) FRAME_BUSY = 1'b0;
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 16; k++) begin
                kinds[k] = (r == 0) ? 2'(k) : 2'(rnd());
                ids[k] = 8'(rnd());
            end
            xfer_w(sel(1'b0), `REG_SLOT, 1);
            chk(8'(ok), 8'h01);
            xfer_w(sel(1'b0), `REG_FRAME, 0);
            chk(8'(ok), 8'h00);
            for (t = 0; t < 50 && ok !== 1'b1; t++) xfer_w(sel(1'b0), `REG_FRAME, 0);
            if (ok !== 1'b1) begin
                n_fail++;
                $display("ERROR %0t: sequencer never released bus", $time);
            end
            chk(8'(cmd_exp), 8'(16 * (r + 1)));
            rd(19);
            for (int i = 0; i < 19; i++) chk(rbuf[i], exp_byte(i));
        end
        xfer_w(sel(1'b0), `REG_SLOT, 0);
        rd(3);
        for (int i = 0; i < 3; i++) chk(rbuf[i], `READ_FILL);
        chk(8'(cmd_exp), 8'h20);
        chk(8'(n_tx), 8'h01);
        chk(8'(SDA_OUT), 8'h00);
        xfer_w(sel(1'b0) ^ 8'h02, `REG_FRAME, 0);
        chk(8'(ok), 8'h00);
        xfer_w(sel(1'b0), 8'h07, 0);
        chk(8'(ok), 8'h00);
        final_report();
    end
endmodule // tb_top

`default_nettype wire
